// >>> hw/lan_phy_power_control.sv
// PHY sleep, power control and wake logic in the deep-sleep well.
`timescale 1ns/1ps
`include "lan_phy_power_defs.svh"
// Overview of the block.
// The block sits in the deep-sleep well and keeps three pins in order: the LAN sleep output,
// the PHY power control pin with its output enable, and the filtered wake input from the PHY.
// The sleep output is a plain registered decode of the firmware enable and the sleep request.
// The power control pin is run by a three-state machine: released, driven high, driven low.
// Released means the output enable is low and the board pull decides the level at the PHY.
// Driving low is the only way to put the PHY into its low-power state, so it is guarded
// against the sleep output: the low drive is never allowed while sleep is asserted.
// In the low-power system states the pin is released unless a wake is pending or the
// management engine asks for it, which lets the engine keep the PHY under its own control.
// After any reset the pin stays released for a hold time, so the PHY sees no drive
// during reset and immediately after it, while the well supply settles.
// The wake input is filtered over a number of cycles; one event is reported per assertion,
// and the sticky pending flag stays up until it is acknowledged.
// Limitation: all inputs are taken as synchronous to the clock; the wake pin must be
// synchronised upstream if it comes straight from the board.
module lan_phy_power_control
   import lan_phy_power_pkg::*;
#(
   parameter int WAKE_FILTER_CYC = `LPP_WAKE_FILTER_CYC,
   parameter int PC_HOLD_CYC     = `LPP_PC_HOLD_CYC
) (
   input  wire logic                         clk_sys_i,
   input  wire logic                         sys_rst_i,
   input  wire logic                         deep_well_power_good_i,
   input  wire logic                         lan_enable_cfg_i,
   input  wire logic [`LPP_SYS_STATE_W-1:0]  sys_state_i,
   input  wire logic                         lan_sleep_req_i,
   input  wire logic                         phy_idle_req_i,
   input  wire logic                         engine_phy_req_i,
   input  wire logic                         phy_wake_n_i,
   input  wire logic                         wake_ack_i,
   output logic                              lan_sleep_n_o,
   output logic                              phy_power_ctl_o,
   output logic                              phy_power_ctl_oe_o,
   output logic                              wake_event_o,
   output logic                              wake_pending_o
);
   import lan_phy_power_pkg::*;

   // Either reset source clears the well; power-good low is the well's own reset.
   logic        rst;
   logic [7:0]  wake_cnt;
   logic        wake_seen;
   logic [7:0]  hold_cnt;
   logic        low_power_sys;
   logic        want_low;
   logic        want_drive;
   pc_state_t   pc_state;
   pc_state_t   next_pc_state;
   logic        wake_hit;

   // The wake qualifier feeds both the pulse and the sticky flag, so it lives in one place.
   // It is true on the single cycle in which the filter count completes.
   function automatic logic wake_qualifies(
      input logic [7:0] cnt,
      input logic       wake_n,
      input logic       seen
   );
      return (cnt == 8'(WAKE_FILTER_CYC - 1)) && !wake_n && !seen;
   endfunction

   // Soft-off and deep sleep are the low-power states; the spare code is treated as working.
   function automatic logic is_low_power(
      input logic [`LPP_SYS_STATE_W-1:0] state
   );
      return (state == `LPP_SYS_SOFT_OFF) || (state == `LPP_SYS_DEEP_SLEEP);
   endfunction

   assign rst           = sys_rst_i | ~deep_well_power_good_i;
   assign low_power_sys = is_low_power(sys_state_i);
   assign wake_hit      = wake_qualifies(wake_cnt, phy_wake_n_i, wake_seen);

   // Sleep output: low when the controller is disabled or the system asks for LAN sleep.
   // It resets low, so a disabled controller never shows a high pulse at power-up.
   always_ff @(posedge clk_sys_i) begin
      if (rst) begin
         lan_sleep_n_o <= 1'b0;
      end else if (!lan_enable_cfg_i) begin
         lan_sleep_n_o <= 1'b0;
      end else begin
         lan_sleep_n_o <= ~lan_sleep_req_i;
      end
   end

   // Wake input is filtered so a glitch on the pulled-up line is not taken as an event.
   // The seen flag blocks a second event until the line has gone high again.
   always_ff @(posedge clk_sys_i) begin
      if (rst) begin
         wake_cnt  <= 8'h00;
         wake_seen <= 1'b0;
      end else if (phy_wake_n_i) begin
         wake_cnt  <= 8'h00;
         wake_seen <= 1'b0;
      end else if (wake_cnt < 8'(WAKE_FILTER_CYC - 1)) begin
         wake_cnt <= wake_cnt + 8'h01;
      end else begin
         wake_seen <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst) begin
         wake_event_o <= 1'b0;
      end else begin
         wake_event_o <= wake_hit;
      end
   end

   // A new event wins over an acknowledge in the same cycle.
   always_ff @(posedge clk_sys_i) begin
      if (rst) begin
         wake_pending_o <= 1'b0;
      end else if (wake_hit) begin
         wake_pending_o <= 1'b1;
      end else if (wake_ack_i) begin
         wake_pending_o <= 1'b0;
      end
   end

   // Drive decision. Low is only allowed with lan_sleep_n high, checked on the registered output.
   always_comb begin
      // The low drive needs the sleep output high now and still high after this edge.
      // That is exactly an enabled controller with no sleep request; checking only the request
      // would let a disable drop the sleep output on the same edge that the pin goes low.
      want_low   = phy_idle_req_i
                   && lan_sleep_n_o
                   && lan_enable_cfg_i
                   && !lan_sleep_req_i;
      want_drive = !low_power_sys || wake_pending_o || engine_phy_req_i;
      next_pc_state = PC_UNDRIVEN;
      case (pc_state)
         PC_UNDRIVEN: begin
            if (want_drive && hold_cnt == 8'h00) begin
               next_pc_state = want_low ? PC_DRIVE_LO : PC_DRIVE_HI;
            end
         end
         PC_DRIVE_HI: begin
            if (!want_drive) begin
               next_pc_state = PC_UNDRIVEN;
            end else if (want_low) begin
               next_pc_state = PC_DRIVE_LO;
            end else begin
               next_pc_state = PC_DRIVE_HI;
            end
         end
         PC_DRIVE_LO: begin
            if (!want_drive) begin
               next_pc_state = PC_UNDRIVEN;
            end else if (!want_low) begin
               next_pc_state = PC_DRIVE_HI;
            end else begin
               next_pc_state = PC_DRIVE_LO;
            end
         end
         default: begin
            next_pc_state = PC_UNDRIVEN;
         end
      endcase
   end

   // After reset the pin stays released for a hold time so it is undriven right after release.
   // The hold only gates leaving the released state; a later release of the pin is immediate.
   always_ff @(posedge clk_sys_i) begin
      if (rst) begin
         hold_cnt <= 8'(PC_HOLD_CYC);
      end else if (hold_cnt != 8'h00) begin
         hold_cnt <= hold_cnt - 8'h01;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst) begin
         pc_state <= PC_UNDRIVEN;
      end else begin
         pc_state <= next_pc_state;
      end
   end

   // Outputs follow the next state so the pin and its enable are flip-flops, not decodes.
   // The pin value rests high when released; enabling the driver goes straight to a low when want_low is set.
   always_ff @(posedge clk_sys_i) begin
      if (rst) begin
         phy_power_ctl_o    <= 1'b1;
         phy_power_ctl_oe_o <= 1'b0;
      end else begin
         phy_power_ctl_o    <= (next_pc_state != PC_DRIVE_LO);
         phy_power_ctl_oe_o <= (next_pc_state != PC_UNDRIVEN);
      end
   end
endmodule

// >>> hw/lan_phy_power_defs.svh
// Constant definitions for the LAN PHY power and wake control block.
`ifndef LAN_PHY_POWER_DEFS_SVH
`define LAN_PHY_POWER_DEFS_SVH
`define LPP_SYS_STATE_W     2
`define LPP_SYS_WORKING     2'h0
`define LPP_SYS_SOFT_OFF    2'h1
`define LPP_SYS_DEEP_SLEEP  2'h2
`define LPP_CLK_PERIOD_NS   8
`define LPP_WAKE_FILTER_NS  64
`define LPP_WAKE_FILTER_CYC ((`LPP_WAKE_FILTER_NS + `LPP_CLK_PERIOD_NS - 1) / `LPP_CLK_PERIOD_NS)
`define LPP_PC_HOLD_NS      800
`define LPP_PC_HOLD_CYC     ((`LPP_PC_HOLD_NS + `LPP_CLK_PERIOD_NS - 1) / `LPP_CLK_PERIOD_NS)
`endif

// >>> hw/lan_phy_power_pkg.sv
// Types for the LAN PHY power and wake control block.
package lan_phy_power_pkg;
   typedef enum logic [1:0] {
      PC_UNDRIVEN = 2'b00,
      PC_DRIVE_HI = 2'b01,
      PC_DRIVE_LO = 2'b10
   } pc_state_t;
endpackage

// >>> test/lan_phy_power_props_properties.sv
// Port checker for the LAN PHY power and wake block.
`timescale 1ns/1ps
module lan_phy_power_props (
   input wire logic       clk_sys_i,
   input wire logic       sys_rst_i,
   input wire logic       deep_well_power_good_i,
   input wire logic       lan_enable_cfg_i,
   input wire logic       lan_sleep_req_i,
   input wire logic       phy_idle_req_i,
   input wire logic [1:0] sys_state_i,
   input wire logic       engine_phy_req_i,
   input wire logic       phy_wake_n_i,
   input wire logic       wake_ack_i,
   input wire logic       lan_sleep_n_o,
   input wire logic       phy_power_ctl_o,
   input wire logic       phy_power_ctl_oe_o,
   input wire logic       wake_event_o,
   input wire logic       wake_pending_o
);
   wire rst = sys_rst_i | ~deep_well_power_good_i;
   wire awake = lan_enable_cfg_i & ~lan_sleep_req_i & ~rst;
   wire quiet = (sys_state_i == 2'h1 || sys_state_i == 2'h2) & ~wake_pending_o & ~engine_phy_req_i;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst);
   sequence wake_low; phy_wake_n_i ##1 !phy_wake_n_i [*8]; endsequence
   AST_LO_AWAKE: assert property (phy_power_ctl_oe_o && !phy_power_ctl_o |-> lan_sleep_n_o)
      else $error("ctl low in sleep");
   AST_SLEEP_OFF: assert property (!$past(lan_enable_cfg_i) |-> !lan_sleep_n_o)
      else $error("sleep high when off");
   AST_SLEEP_ON: assert property ($past(awake) |-> lan_sleep_n_o)
      else $error("sleep low when on");
   AST_RST_UNDRIVEN: assert property (disable iff (1'b0) rst |=> !phy_power_ctl_oe_o && !lan_sleep_n_o)
      else $error("driven in reset");
   AST_LP_UNDRIVEN: assert property ($past(quiet) |-> !phy_power_ctl_oe_o)
      else $error("driven in low power");
   AST_WAKE: assert property (wake_low |=> wake_event_o && wake_pending_o)
      else $error("wake missed");
   AST_EV_PULSE: assert property (wake_event_o |=> !wake_event_o)
      else $error("event too long");
   AST_PEND: assert property (wake_pending_o && !wake_ack_i |=> wake_pending_o)
      else $error("pending lost");
   AST_POST_RST: assert property ($past(rst) |-> !phy_power_ctl_oe_o)
      else $error("driven right after reset");
   AST_IDLE_LO: assert property (phy_power_ctl_oe_o && awake && lan_sleep_n_o && phy_idle_req_i && !quiet
      |=> phy_power_ctl_oe_o && !phy_power_ctl_o)
      else $error("ctl not low when idle");
endmodule
bind lan_phy_power_control lan_phy_power_props props_i (.*);

// >>> test/phy_model.sv
// Behavioural PHY with its supply switch.
`timescale 1ns/1ps
module phy_model (
   input  wire logic lan_sleep_n_i,
   input  wire logic wake_req_i,
   output logic      powered_o,
   output logic      phy_wake_n_o
);
   // Supply is kept while sleep is deasserted and may be cut otherwise.
   assign powered_o = lan_sleep_n_i;
   // Driven both ways: low on a wake request, high otherwise, standing in for the board pull-up.
   assign phy_wake_n_o = wake_req_i ? 1'h0 : 1'h1;
endmodule

// >>> test/tb.sv
// Self-checking bench for the LAN PHY power and wake block.
`timescale 1ns/1ps
module tb;
   logic clk_sys_i = 0, sys_rst_i = 1, pg = 1, cfg = 0, req = 0, idle = 0, eng = 0, ack = 0, wreq = 0;
   logic [1:0] st = 2'h0;
   logic sleep_n, ctl, oe, ev, pend, wake_n;
   int errors = 0, n_tests = 0;
   lan_phy_power_control lan_phy_power_control_i (.clk_sys_i, .sys_rst_i, .deep_well_power_good_i(pg),
      .lan_enable_cfg_i(cfg), .sys_state_i(st), .lan_sleep_req_i(req), .phy_idle_req_i(idle),
      .engine_phy_req_i(eng), .phy_wake_n_i(wake_n), .wake_ack_i(ack), .lan_sleep_n_o(sleep_n),
      .phy_power_ctl_o(ctl), .phy_power_ctl_oe_o(oe), .wake_event_o(ev), .wake_pending_o(pend));
   phy_model phy_model_i (.lan_sleep_n_i(sleep_n), .wake_req_i(wreq), .powered_o(), .phy_wake_n_o(wake_n));
   initial forever #4 clk_sys_i = ~clk_sys_i;
   function logic exp_sleep(logic c, logic r);
      return c & ~r;
   endfunction
   task check(string nm, logic seen, logic exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %b seen %b", nm, exp, seen);
      end
   endtask
   task stop_test;
      $display("checks %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task step(int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask
   initial begin
      #20000;
      errors++;
      stop_test;
   end
   initial begin
      void'($urandom(32'h33FD));
      step(6); check("oe_rst", oe, 1'h0);
      sys_rst_i = 0;
      step(2); check("oe_post", oe, 1'h0);
      step(110);
      for (int i = 0; i < 400; i++) begin
         {req, idle, eng, ack} = 4'($urandom);
         cfg = ($urandom % 4) != 0;
         st = 2'($urandom);
         wreq = ($urandom % 8) == 0;
         step(1); check("sleep_n", sleep_n, exp_sleep(cfg, req));
         check("lo_awake", oe & ~ctl & ~sleep_n, 1'h0);
      end
      {cfg, req, idle, eng, ack, wreq} = 6'h2A;
      st = 2'h0;
      step(3); check("ctl_lo", oe & ~ctl, 1'h1);
      ack = 0;
      wreq = 1;
      step(8); check("wake_ev", ev & pend, 1'h1);
      {wreq, idle, ack} = 3'h1;
      st = 2'h1;
      step(3); check("lp_oe", oe, 1'h0);
      pg = 0;
      step(1); check("pg_rst", sleep_n | oe, 1'h0);
      pg = 1;
      step(2); check("pg_post", oe, 1'h0);
      stop_test;
   end
endmodule
